// [core/mcd_cfg.svh]
// Constants of the core datapath: vectors, memory map, stack geometry, adjust values.
// Assumes inclusion by name from the datapath package and modules.
`ifndef MCD_CFG_SVH
`define MCD_CFG_SVH

`define MCD_PC_W        11
`define MCD_IDX_W       12
`define MCD_IDX_LO_W    4
`define MCD_NIB_W       4
`define MCD_BYTE_W      8
`define MCD_PC_RESET    11'h000
`define MCD_VEC_SRC0    11'h014
`define MCD_VEC_SRC1    11'h018
`define MCD_VEC_SRC2    11'h010
`define MCD_VEC_SRC3    11'h01C
`define MCD_VEC_SRC5    11'h024
`define MCD_VEC_SRC6    11'h028
`define MCD_IDX_RESET   12'h000
`define MCD_STK_DEPTH   8
`define MCD_SP_W        3
`define MCD_SP_RESET    3'h7
`define MCD_SP_TOP      3'h7
`define MCD_RAM_WORDS   96
`define MCD_RAM_IDX_W   7
`define MCD_DIR_ADDR_W  7
`define MCD_IDX_ADDR_W  9
`define MCD_HOLE_LO     7'h50
`define MCD_HOLE_HI     7'h6F
`define MCD_HOLE_SIZE   7'h20
`define MCD_WR_BASE     7'h70
`define MCD_DEC_MAX     4'h9
`define MCD_DAA_FIX     4'h6
`define MCD_DAA_CMAX    4'h3
`define MCD_DAS_FIX     4'hA
`define MCD_DAS_MIN     4'h6

`endif

// [core/mcd_pkg.sv]
// Types shared by the core datapath files.
// Assumes the constants header sits in the include path.
`include "mcd_cfg.svh"
package mcd_pkg;
  typedef logic [`MCD_PC_W-1:0]   mcd_pc_t;
  typedef logic [`MCD_IDX_W-1:0]  mcd_idx_t;
  typedef logic [`MCD_NIB_W-1:0]  mcd_nib_t;
  typedef logic [`MCD_BYTE_W-1:0] mcd_byte_t;
  typedef logic [`MCD_SP_W-1:0]   mcd_sp_t;

  // Program counter operation requested by the sequencer
  typedef enum logic [2:0] {
    MCD_PC_HOLD = 3'h0,
    MCD_PC_ADV  = 3'h1,
    MCD_PC_JUMP = 3'h2,
    MCD_PC_CALL = 3'h3,
    MCD_PC_IRQ  = 3'h4,
    MCD_PC_RET  = 3'h5
  } mcd_pc_op_t;

  // Accumulator operation
  typedef enum logic [1:0] {
    MCD_AC_HOLD = 2'h0,
    MCD_AC_LOAD = 2'h1,
    MCD_AC_DAA  = 2'h2,
    MCD_AC_DAS  = 2'h3
  } mcd_ac_op_t;
endpackage : mcd_pkg

// [core/mcd_stack_if.sv]
// Carrier between the datapath and its return stack.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface mcd_stack_if;
  import mcd_pkg::*;
  logic    push;
  logic    pop;
  mcd_pc_t push_data;
  mcd_pc_t top_data;
  mcd_sp_t sp;

  modport core (output push, output pop, output push_data, input top_data, input sp);
  modport stk  (input push, input pop, input push_data, output top_data, output sp);
endinterface : mcd_stack_if

// [core/mcd_stack.sv]
// Eight-level return stack with wrapping pointer and no overflow flag.
// Assumes push and pop are never requested together.
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_stack (
  input  wire logic CORE_CLK_IN,
  input  wire logic RESETN_IN,
  input  wire logic CLK_EN_IN,
  mcd_stack_if.stk  stk
);
  import mcd_pkg::*;

  mcd_pc_t entry_mem [`MCD_STK_DEPTH];
  mcd_sp_t sp_reg;
  mcd_sp_t sp_next;

  // Pointer moves up on push, down on pop, wrapping both ways
  always_comb begin
    sp_next = sp_reg;
    if (stk.push) begin
      sp_next = sp_reg + 3'h1;
    end else if (stk.pop) begin
      sp_next = sp_reg - 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sp_reg <= `MCD_SP_RESET;
    end else if (CLK_EN_IN) begin
      sp_reg <= sp_next;
    end
  end

  // Push lands at the new pointer, overwriting the oldest entry when full
  always_ff @(posedge CORE_CLK_IN) begin
    if (CLK_EN_IN && stk.push) begin
      entry_mem[sp_next] <= stk.push_data;
    end
  end

  assign stk.top_data = entry_mem[sp_reg];
  assign stk.sp       = sp_reg;

  // Assertions on pointer movement
  AST_STK_PUSH_UP: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    CLK_EN_IN && stk.push |=> sp_reg == 3'($past(sp_reg) + 3'h1))
    else $error("Stack pointer did not advance on push");
  AST_STK_POP_DOWN: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    CLK_EN_IN && stk.pop && !stk.push |=> sp_reg == 3'($past(sp_reg) - 3'h1))
    else $error("Stack pointer did not retreat on pop");
endmodule : mcd_stack

// [core/mcd_datapath.sv]
// Core datapath: program counter, vectors, index pointer, return stack, data memory, decimal adjust.
// Assumes the sequencer drives one operation per enabled cycle from the same clock.
`timescale 1ns/1ps
`include "mcd_cfg.svh"
// Function
// - Reset starts at 000H; source 0 vectors to 014H, source 1 to 018H.
// - Source 2 to 010H, 3 to 01CH, 5 to 024H, 6 to 028H.
// - Table reads addressed by index pointer; byte or nibble delivery per instruction.
// - Index pointer is 12 bits: 4-bit low part, 8-bit high part.
// - Load-index-low copies selected memory nibble into low part only.
// - Load-index-high fills high part from memory nibble and operand register.
// - Call or interrupt pushes program counter, last in first out.
// - Stack holds eight 11-bit entries, no overflow flag.
// - Push when full wraps pointer to 0 and overwrites entry 0.
// - Return loads program counter from latest entry then decrements pointer.
// - Return underflow restores entry 0, then wraps pointer from 0 to 7.
// - 96 nibbles in 00h-7Fh; 50h-6Fh absent.
// - Direct addressing takes address from instruction field, 00H-7FH.
// - Indexed addressing uses index pointer bits 6:0 over 00H-7FH, same hole excluded.
// - 70H-7FH serve as general storage and as working registers.
// - Decimal adjust after add: A-F/carry clear or 0-3/carry set adds 6.
// - Decimal adjust after subtract: 6-F with carry clear adds A.
// - Program counter is 11 bits, increments per instruction, clears on reset.
module mcd_datapath (
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RESETN_IN,
  input  wire logic               CLK_EN_IN,
  input  wire mcd_pkg::mcd_pc_op_t PC_OP_IN,
  input  wire mcd_pkg::mcd_pc_t   PC_TARGET_IN,
  input  wire logic [2:0]         IRQ_SRC_IN,
  input  wire mcd_pkg::mcd_ac_op_t AC_OP_IN,
  input  wire mcd_pkg::mcd_nib_t  AC_DATA_IN,
  input  wire logic               CF_LOAD_IN,
  input  wire logic               CF_DATA_IN,
  input  wire logic               LOAD_INDEX_LOW_OP_IN,
  input  wire logic               LOAD_INDEX_HIGH_OP_IN,
  input  wire logic               RAM_INDEXED_IN,
  input  wire logic [6:0]         RAM_DIR_ADDR_IN,
  input  wire logic               RAM_WE_IN,
  input  wire mcd_pkg::mcd_nib_t  RAM_WDATA_IN,
  input  wire logic [3:0]         WR_SEL_IN,
  input  wire logic               TABLE_NIBBLE_IN,
  input  wire mcd_pkg::mcd_byte_t TABLE_DATA_IN,
  output logic                    TABLE_CAPTURE_IN_UNUSED_OUT,
  output mcd_pkg::mcd_pc_t        PROGRAM_COUNTER_OUT,
  output mcd_pkg::mcd_idx_t       INDEX_POINTER_OUT,
  output mcd_pkg::mcd_idx_t       TABLE_ADDR_OUT,
  output mcd_pkg::mcd_byte_t      TABLE_DATA_OUT,
  output mcd_pkg::mcd_nib_t       RAM_RDATA_OUT,
  output logic                    RAM_HOLE_OUT,
  output mcd_pkg::mcd_nib_t       WR_DATA_OUT,
  output mcd_pkg::mcd_nib_t       MAIN_OPERAND_OUT,
  output logic                    CARRY_FLAG_OUT,
  output mcd_pkg::mcd_sp_t        STACK_PTR_OUT
);
  import mcd_pkg::*;

  // Map a 7-bit memory address onto an array slot, flagging the hole
  function automatic logic [7:0] ram_slot(input logic [6:0] addr);
    logic [6:0] slot;
    logic       hole;
    hole = (addr >= `MCD_HOLE_LO) && (addr <= `MCD_HOLE_HI);
    slot = (addr > `MCD_HOLE_HI) ? 7'(addr - `MCD_HOLE_SIZE) : addr;
    return {hole, slot};
  endfunction : ram_slot

  // Vector for an interrupt source; undefined sources fall to the reset vector
  function automatic mcd_pc_t irq_vector(input logic [2:0] src);
    mcd_pc_t vec;
    unique case (src)
      3'h0:    vec = `MCD_VEC_SRC0;
      3'h1:    vec = `MCD_VEC_SRC1;
      3'h2:    vec = `MCD_VEC_SRC2;
      3'h3:    vec = `MCD_VEC_SRC3;
      3'h5:    vec = `MCD_VEC_SRC5;
      3'h6:    vec = `MCD_VEC_SRC6;
      default: vec = `MCD_PC_RESET;
    endcase
    return vec;
  endfunction : irq_vector

  mcd_stack_if stk_if ();

  mcd_stack u_stack (
    .CORE_CLK_IN (CORE_CLK_IN),
    .RESETN_IN   (RESETN_IN),
    .CLK_EN_IN   (CLK_EN_IN),
    .stk         (stk_if.stk)
  );

  mcd_pc_t   pc_reg;
  mcd_pc_t   pc_next;
  mcd_idx_t  index_pointer_reg;
  mcd_nib_t  ac_reg;
  mcd_nib_t  ac_next;
  logic      cf_reg;
  logic      cf_next;
  mcd_nib_t  ram_mem [`MCD_RAM_WORDS];
  logic [6:0] ram_addr;
  logic [7:0] ram_map;
  logic [7:0] wr_map;
  logic      ram_hole;
  mcd_nib_t  ram_rd;
  mcd_byte_t table_reg;
  mcd_nib_t  ram_rdata_reg;
  mcd_nib_t  wr_data_reg;
  logic      hole_reg;

  // Stack requests follow the program counter operation
  assign stk_if.push      = (PC_OP_IN == MCD_PC_CALL) || (PC_OP_IN == MCD_PC_IRQ);
  assign stk_if.pop       = (PC_OP_IN == MCD_PC_RET);
  assign stk_if.push_data = pc_reg;

  // Next program counter per operation
  always_comb begin
    pc_next = pc_reg;
    unique case (PC_OP_IN)
      MCD_PC_HOLD: pc_next = pc_reg;
      MCD_PC_ADV:  pc_next = 11'(pc_reg + 11'h001);
      MCD_PC_JUMP: pc_next = PC_TARGET_IN;
      MCD_PC_CALL: pc_next = PC_TARGET_IN;
      MCD_PC_IRQ:  pc_next = irq_vector(IRQ_SRC_IN);
      MCD_PC_RET:  pc_next = stk_if.top_data;
      default:     pc_next = pc_reg;
    endcase
  end

  // Program counter, cleared by reset
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pc_reg <= `MCD_PC_RESET;
    end else if (CLK_EN_IN) begin
      pc_reg <= pc_next;
    end
  end

  // Memory address: instruction field or index pointer bits 6:0
  assign ram_addr = RAM_INDEXED_IN ? index_pointer_reg[6:0] : RAM_DIR_ADDR_IN;
  assign ram_map  = ram_slot(ram_addr);
  assign ram_hole = ram_map[7];
  assign ram_rd   = ram_hole ? 4'h0 : ram_mem[ram_map[6:0]];
  assign wr_map   = ram_slot(7'(`MCD_WR_BASE + {3'h0, WR_SEL_IN}));

  // Memory write, dropped inside the hole
  always_ff @(posedge CORE_CLK_IN) begin
    if (CLK_EN_IN && RAM_WE_IN && !ram_hole) begin
      ram_mem[ram_map[6:0]] <= RAM_WDATA_IN;
    end
  end

  // Index pointer low and high parts
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      index_pointer_reg <= `MCD_IDX_RESET;
    end else if (CLK_EN_IN) begin
      if (LOAD_INDEX_LOW_OP_IN) begin
        index_pointer_reg[3:0] <= ram_rd;
      end
      if (LOAD_INDEX_HIGH_OP_IN) begin
        index_pointer_reg[11:4] <= {ram_rd, ac_reg};
      end
    end
  end

  // Operand register and carry, with decimal adjust
  always_comb begin
    ac_next = ac_reg;
    cf_next = CF_LOAD_IN ? CF_DATA_IN : cf_reg;
    unique case (AC_OP_IN)
      MCD_AC_HOLD: ac_next = ac_reg;
      MCD_AC_LOAD: ac_next = AC_DATA_IN;
      MCD_AC_DAA: begin
        if (!cf_reg && ac_reg > `MCD_DEC_MAX) begin
          ac_next = 4'(ac_reg + `MCD_DAA_FIX);
          cf_next = 1'b1;
        end else if (cf_reg && ac_reg <= `MCD_DAA_CMAX) begin
          ac_next = 4'(ac_reg + `MCD_DAA_FIX);
          cf_next = 1'b1;
        end else begin
          cf_next = cf_reg;
        end
      end
      MCD_AC_DAS: begin
        if (!cf_reg && ac_reg >= `MCD_DAS_MIN) begin
          ac_next = 4'(ac_reg + `MCD_DAS_FIX);
        end
        cf_next = cf_reg;
      end
      default: ac_next = ac_reg;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ac_reg <= 4'h0;
      cf_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      ac_reg <= ac_next;
      cf_reg <= cf_next;
    end
  end

  // Table data captured from the store, nibble picked by pointer bit 0
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      table_reg <= 8'h00;
    end else if (CLK_EN_IN) begin
      if (TABLE_NIBBLE_IN) begin
        table_reg <= {4'h0, index_pointer_reg[0] ? TABLE_DATA_IN[7:4] : TABLE_DATA_IN[3:0]};
      end else begin
        table_reg <= TABLE_DATA_IN;
      end
    end
  end

  // Registered memory, working register and hole views
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ram_rdata_reg <= 4'h0;
      wr_data_reg   <= 4'h0;
      hole_reg      <= 1'b0;
    end else if (CLK_EN_IN) begin
      ram_rdata_reg <= ram_rd;
      wr_data_reg   <= ram_mem[wr_map[6:0]];
      hole_reg      <= ram_hole;
    end
  end

  // Table address: byte mode uses the pointer, nibble mode halves it
  assign TABLE_ADDR_OUT = TABLE_NIBBLE_IN ? {1'b0, index_pointer_reg[11:1]} : index_pointer_reg;

  assign TABLE_CAPTURE_IN_UNUSED_OUT = 1'b0;
  assign PROGRAM_COUNTER_OUT = pc_reg;
  assign INDEX_POINTER_OUT   = index_pointer_reg;
  assign TABLE_DATA_OUT      = table_reg;
  assign RAM_RDATA_OUT       = ram_rdata_reg;
  assign RAM_HOLE_OUT        = hole_reg;
  assign WR_DATA_OUT         = wr_data_reg;
  assign MAIN_OPERAND_OUT    = ac_reg;
  assign CARRY_FLAG_OUT      = cf_reg;
  assign STACK_PTR_OUT       = stk_if.sp;

  // Assertions
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  AST_IRQ_SRC0: assert property (
    CLK_EN_IN && PC_OP_IN == MCD_PC_IRQ && IRQ_SRC_IN == 3'h0 |=> pc_reg == 11'h014)
    else $error("Source 0 vector wrong");
  AST_IRQ_SRC2: assert property (
    CLK_EN_IN && PC_OP_IN == MCD_PC_IRQ && IRQ_SRC_IN == 3'h2 |=> pc_reg == 11'h010)
    else $error("Source 2 vector wrong");
  AST_TABLE_ADDR: assert property (
    !TABLE_NIBBLE_IN |-> TABLE_ADDR_OUT == INDEX_POINTER_OUT)
    else $error("Table address not from index pointer");
  AST_IDX_LOW: assert property (
    CLK_EN_IN && LOAD_INDEX_LOW_OP_IN && !LOAD_INDEX_HIGH_OP_IN |=>
      index_pointer_reg[3:0] == $past(ram_rd) && index_pointer_reg[11:4] == $past(index_pointer_reg[11:4]))
    else $error("Index low load wrong");
  AST_IDX_HIGH: assert property (
    CLK_EN_IN && LOAD_INDEX_HIGH_OP_IN |=> index_pointer_reg[11:4] == {$past(ram_rd), $past(ac_reg)})
    else $error("Index high load wrong");
  AST_CALL_RET: assert property (
    CLK_EN_IN && PC_OP_IN == MCD_PC_CALL ##1 CLK_EN_IN && PC_OP_IN == MCD_PC_RET
      |=> pc_reg == $past(pc_reg, 2))
    else $error("Return did not restore pushed counter");
  AST_PUSH_WRAP: assert property (
    CLK_EN_IN && stk_if.push && stk_if.sp == 3'h7 |=> stk_if.sp == 3'h0)
    else $error("Push did not wrap to 0");
  AST_RET_LOAD: assert property (
    CLK_EN_IN && PC_OP_IN == MCD_PC_RET |=> pc_reg == $past(stk_if.top_data))
    else $error("Return counter wrong");
  AST_POP_WRAP: assert property (
    CLK_EN_IN && PC_OP_IN == MCD_PC_RET && stk_if.sp == 3'h0 |=> stk_if.sp == 3'h7)
    else $error("Underflow did not wrap to 7");
  AST_HOLE_READ: assert property (
    CLK_EN_IN && ram_addr >= 7'h50 && ram_addr <= 7'h6F |=> RAM_HOLE_OUT && RAM_RDATA_OUT == 4'h0)
    else $error("Hole access not flagged");
  AST_DAA_HI: assert property (
    CLK_EN_IN && AC_OP_IN == MCD_AC_DAA && !cf_reg && ac_reg > 4'h9 |=>
      ac_reg == 4'($past(ac_reg) + 4'h6) && cf_reg)
    else $error("Add adjust wrong");
  AST_DAS_FIX: assert property (
    CLK_EN_IN && AC_OP_IN == MCD_AC_DAS && !cf_reg && !CF_LOAD_IN && ac_reg >= 4'h6 |=>
      ac_reg == 4'($past(ac_reg) + 4'hA) && !cf_reg)
    else $error("Subtract adjust wrong");
  AST_DAA_KEEP: assert property (
    CLK_EN_IN && AC_OP_IN == MCD_AC_DAA && cf_reg && ac_reg > 4'h3 |=>
      $stable(ac_reg) && $stable(cf_reg))
    else $error("Uncovered adjust changed state");
  AST_PC_ADV: assert property (
    CLK_EN_IN && PC_OP_IN == MCD_PC_ADV |=> pc_reg == 11'($past(pc_reg) + 11'h001))
    else $error("Counter did not advance by one");

  COV_CALL_RET: cover property (CLK_EN_IN && PC_OP_IN == MCD_PC_CALL ##[1:20] PC_OP_IN == MCD_PC_RET);
  COV_POP_WRAP: cover property (CLK_EN_IN && PC_OP_IN == MCD_PC_RET && stk_if.sp == 3'h0);
  COV_DAA_CARRY: cover property (CLK_EN_IN && AC_OP_IN == MCD_AC_DAA && !cf_reg && ac_reg > 4'h9);
  COV_HOLE_WRITE: cover property (CLK_EN_IN && RAM_WE_IN && ram_hole);
endmodule : mcd_datapath

// [bench/mcd_table_model.sv]
// Table store model answering the datapath's table address in the same cycle.
// Assumes a combinational store and the shared datapath package.
`timescale 1ns/1ps
module mcd_table_model (
  input  wire mcd_pkg::mcd_idx_t  addr_in,
  output mcd_pkg::mcd_byte_t      data_out
);
  import mcd_pkg::*;
  // Byte content scrambled from the address so that neighbours always differ
  assign data_out = {addr_in[3:0], addr_in[7:4]} ^ 8'h3C;
endmodule : mcd_table_model

// [bench/testbench.sv]
// Self-checking bench of the core datapath with a table store model.
// Assumes the datapath package and constants header are compiled first.
`timescale 1ns/1ps
module testbench;
  import mcd_pkg::*;
  logic       clk      = 1'b0;
  logic       rst_n    = 1'b0;
  logic       en       = 1'b1;
  mcd_pc_op_t pc_op    = MCD_PC_HOLD;
  mcd_pc_t    pc_tgt   = 11'h000;
  logic [2:0] irq_src  = 3'h0;
  mcd_ac_op_t ac_op    = MCD_AC_HOLD;
  mcd_nib_t   ac_d     = 4'h0;
  logic       cf_ld    = 1'b0;
  logic       cf_d     = 1'b0;
  logic       idx_lo   = 1'b0;
  logic       idx_hi   = 1'b0;
  logic       indexed  = 1'b0;
  logic [6:0] dir_addr = 7'h00;
  logic       we       = 1'b0;
  mcd_nib_t   wdata    = 4'h0;
  logic [3:0] wr_sel   = 4'h0;
  logic       nib_mode = 1'b0;
  mcd_byte_t  tbl_in;
  mcd_pc_t    pc;
  mcd_idx_t   idx;
  mcd_idx_t   tbl_addr;
  mcd_byte_t  tbl_out;
  mcd_nib_t   rdata;
  mcd_nib_t   wr_data;
  mcd_nib_t   ac;
  logic       hole;
  logic       cf;
  mcd_sp_t    sp;
  int         bad_count = 0;
  int         checks    = 0;

  mcd_datapath dut (
    .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .CLK_EN_IN(en), .PC_OP_IN(pc_op), .PC_TARGET_IN(pc_tgt),
    .IRQ_SRC_IN(irq_src), .AC_OP_IN(ac_op), .AC_DATA_IN(ac_d), .CF_LOAD_IN(cf_ld), .CF_DATA_IN(cf_d),
    .LOAD_INDEX_LOW_OP_IN(idx_lo), .LOAD_INDEX_HIGH_OP_IN(idx_hi), .RAM_INDEXED_IN(indexed),
    .RAM_DIR_ADDR_IN(dir_addr), .RAM_WE_IN(we), .RAM_WDATA_IN(wdata), .WR_SEL_IN(wr_sel),
    .TABLE_NIBBLE_IN(nib_mode), .TABLE_DATA_IN(tbl_in), .TABLE_CAPTURE_IN_UNUSED_OUT(),
    .PROGRAM_COUNTER_OUT(pc), .INDEX_POINTER_OUT(idx), .TABLE_ADDR_OUT(tbl_addr), .TABLE_DATA_OUT(tbl_out),
    .RAM_RDATA_OUT(rdata), .RAM_HOLE_OUT(hole), .WR_DATA_OUT(wr_data), .MAIN_OPERAND_OUT(ac),
    .CARRY_FLAG_OUT(cf), .STACK_PTR_OUT(sp));

  mcd_table_model model (.addr_in(tbl_addr), .data_out(tbl_in));

  // Clock of 4 ns period
  always #2 clk = ~clk;

  // Own copy of the table content for expectations
  function automatic mcd_byte_t tbl(input mcd_idx_t a);
    return {a[3:0], a[7:4]} ^ 8'h3C;
  endfunction : tbl

  // Drive this cycle's operations once, then let one clock edge pass
  task automatic tick(input mcd_pc_op_t p = MCD_PC_HOLD, input mcd_ac_op_t a = MCD_AC_HOLD,
                      input logic lo = 1'b0, input logic hi = 1'b0, input logic w = 1'b0, input logic cl = 1'b0);
    pc_op = p;
    ac_op = a;
    idx_lo = lo;
    idx_hi = hi;
    we = w;
    cf_ld = cl;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask : do_reset

  task automatic wr(input logic [6:0] a, input mcd_nib_t d);
    indexed = 1'b0;
    dir_addr = a;
    wdata = d;
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b0, 1'b0, 1'b1);
  endtask : wr

  task automatic rd(input logic [6:0] a, input mcd_nib_t d, input logic h);
    indexed = 1'b0;
    dir_addr = a;
    tick();
    chk(rdata, d);
    chk(hole, h);
  endtask : rd

  // Reset values, counting and freezing by the clock enable
  task automatic t_reset();
    chk(pc, 11'h000);
    chk(sp, 3'h7);
    chk(idx, 12'h000);
    chk({ac, cf}, 5'h00);
    repeat (3) begin
      tick(MCD_PC_ADV);
    end
    chk(pc, 11'h003);
    en = 1'b0;
    tick(MCD_PC_ADV);
    chk(pc, 11'h003);
    en = 1'b1;
  endtask : t_reset

  // Each of the six defined interrupt sources vectors and returns to the interrupted address
  task automatic t_vectors();
    logic [2:0] src [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    mcd_pc_t    vec [6] = '{11'h014, 11'h018, 11'h010, 11'h01C, 11'h024, 11'h028};
    for (int i = 0; i < 6; i++) begin
      pc_tgt = 11'h300;
      tick(MCD_PC_JUMP);
      irq_src = src[i];
      tick(MCD_PC_IRQ);
      chk(pc, vec[i]);
      tick(MCD_PC_RET);
      chk(pc, 11'h300);
    end
  endtask : t_vectors

  // Nine calls overflow the stack, nine returns underflow it
  task automatic t_stack();
    mcd_pc_t stk [8];
    mcd_pc_t cur;
    mcd_sp_t esp;
    do_reset();
    esp = 3'h7;
    cur = 11'h100;
    pc_tgt = cur;
    tick(MCD_PC_JUMP);
    for (int i = 0; i < 9; i++) begin
      esp = esp + 3'h1;
      stk[esp] = cur;
      cur = 11'h200 + 11'(i);
      pc_tgt = cur;
      tick(MCD_PC_CALL);
      chk(pc, cur);
      chk(sp, esp);
    end
    for (int i = 0; i < 9; i++) begin
      tick(MCD_PC_RET);
      chk(pc, stk[esp]);
      esp = esp - 3'h1;
      chk(sp, esp);
    end
  endtask : t_stack

  // Index pointer loads and table reads in byte and nibble form
  task automatic t_index();
    mcd_byte_t b;
    wr(7'h10, 4'hA);
    wr(7'h11, 4'h3);
    ac_d = 4'h5;
    tick(MCD_PC_HOLD, MCD_AC_LOAD);
    dir_addr = 7'h10;
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b1);
    chk(idx, 12'h00A);
    dir_addr = 7'h11;
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b0, 1'b1);
    chk(idx, 12'h35A);
    nib_mode = 1'b0;
    tick();
    chk(tbl_addr, 12'h35A);
    chk(tbl_out, tbl(12'h35A));
    nib_mode = 1'b1;
    tick();
    chk(tbl_addr, 12'h1AD);
    b = tbl(12'h1AD);
    chk(tbl_out, {4'h0, b[3:0]});
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b1);
    chk(idx, 12'h353);
    b = tbl(12'h1A9);
    tick();
    chk(tbl_addr, 12'h1A9);
    chk(tbl_out, {4'h0, b[7:4]});
    nib_mode = 1'b0;
  endtask : t_index

  // Map edges, the hole, working registers and indexed access
  task automatic t_memory();
    wr(7'h4F, 4'hC);
    wr(7'h70, 4'h2);
    wr(7'h50, 4'h9);
    wr(7'h6F, 4'h9);
    wr(7'h7F, 4'h1);
    rd(7'h4F, 4'hC, 1'b0);
    rd(7'h50, 4'h0, 1'b1);
    rd(7'h6F, 4'h0, 1'b1);
    rd(7'h70, 4'h2, 1'b0);
    rd(7'h7F, 4'h1, 1'b0);
    ac_d = 4'h7;
    tick(MCD_PC_HOLD, MCD_AC_LOAD);
    dir_addr = 7'h11;
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b0, 1'b1);
    chk(idx, 12'h373);
    indexed = 1'b1;
    wdata = 4'hE;
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b0, 1'b0, 1'b1);
    rd(7'h73, 4'hE, 1'b0);
    wr_sel = 4'h3;
    tick();
    chk(wr_data, 4'hE);
    ac_d = 4'h5;
    tick(MCD_PC_HOLD, MCD_AC_LOAD);
    tick(MCD_PC_HOLD, MCD_AC_HOLD, 1'b0, 1'b1);
    indexed = 1'b1;
    tick();
    chk(hole, 1'b1);
    indexed = 1'b0;
  endtask : t_memory

  // Decimal adjust cases, each as {op, value, carry, value after, carry after}
  task automatic t_adjust();
    logic [11:0] cs [9] = '{{MCD_AC_DAA, 4'h9, 1'b0, 4'h9, 1'b0}, {MCD_AC_DAA, 4'hC, 1'b0, 4'h2, 1'b1},
      {MCD_AC_DAA, 4'h2, 1'b1, 4'h8, 1'b1}, {MCD_AC_DAA, 4'h5, 1'b1, 4'h5, 1'b1},
      {MCD_AC_DAA, 4'hB, 1'b1, 4'hB, 1'b1}, {MCD_AC_DAS, 4'h9, 1'b1, 4'h9, 1'b1},
      {MCD_AC_DAS, 4'hF, 1'b0, 4'h9, 1'b0}, {MCD_AC_DAS, 4'h6, 1'b0, 4'h0, 1'b0},
      {MCD_AC_DAS, 4'h3, 1'b0, 4'h3, 1'b0}};
    for (int i = 0; i < 9; i++) begin
      ac_d = cs[i][9:6];
      cf_d = cs[i][5];
      tick(MCD_PC_HOLD, MCD_AC_LOAD, 1'b0, 1'b0, 1'b0, 1'b1);
      tick(MCD_PC_HOLD, mcd_ac_op_t'(cs[i][11:10]));
      chk({ac, cf}, cs[i][4:0]);
    end
  endtask : t_adjust

  // Main sequence
  initial begin
    do_reset();
    t_reset();
    t_vectors();
    t_stack();
    t_index();
    t_memory();
    t_adjust();
    close_out();
  end

  // Watchdog well beyond the expected hundred or so cycles
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule : testbench
